/* File: design/rcsg_regs.vh */
// Register offsets, field positions, reset values, address windows and timing counts of the context and stack guard.
`ifndef RCSG_REGS_VH
`define RCSG_REGS_VH

// Register offsets (word index on the register port).
`define RCSG_OFS_CBP      4'h0
`define RCSG_OFS_STP      4'h1
`define RCSG_OFS_OVL      4'h2
`define RCSG_OFS_UNL      4'h3
`define RCSG_OFS_STATUS   4'h4
`define RCSG_OFS_MASK     4'h5
`define RCSG_OFS_CTRL     4'h6

// Reset values.
`define RCSG_CBP_RST      16'hfc00
`define RCSG_STP_RST      16'hfc00
`define RCSG_OVL_RST      16'hfa00
`define RCSG_UNL_RST      16'hfc00
`define RCSG_MASK_RST     2'h0
`define RCSG_CTRL_RST     1'h1

// Status, mask and control field positions.
`define RCSG_ST_OVF       0
`define RCSG_ST_UNF       1
`define RCSG_CTRL_CHK_EN  0

// Internal RAM: 1 KByte as 512 words at the top of segment 0.
`define RCSG_RAM_WORDS    512
`define RCSG_RAM_AW       9
`define RCSG_RAM_BASE     16'hfa00
`define RCSG_RAM_LAST     16'hfdff
`define RCSG_GPR_COUNT    16
`define RCSG_STACK_BYTES  1024

// Event-transfer pointer and bit-addressable windows.
`define RCSG_PTR_LO       16'hfce0
`define RCSG_PTR_HI       16'hfcff
`define RCSG_BIT_LO       16'hfd00
`define RCSG_BIT_HI       16'hfdff

// Timing: machine cycle and clock.
`define RCSG_MCYC_NS      40
`define RCSG_CLK_NS       20
`define RCSG_MCYC_CLKS    (`RCSG_MCYC_NS / `RCSG_CLK_NS)

`endif

/* File: design/rcsg_ram.v */
// Single-clock 1 KByte word RAM with one read-modify-write port and one registered read port.
module rcsg_ram (
    // Clock and enable.
    input wire clk,
    input wire ce,
    // Write port.
    input wire we,
    input wire [8:0] waddr,
    input wire [15:0] wdata,
    input wire [15:0] wmask,
    // Read port.
    input wire [8:0] raddr,
    output reg [15:0] rdata_q
);

    reg [15:0] mem [0:511];

    always @(posedge clk)
    begin
        if (ce)
        begin
            if (we)
            begin
                mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
            end
            rdata_q <= mem[raddr];
        end
    end

endmodule // rcsg_ram

/* File: design/rcsg_core.v */
// Register context, system stack with limit checks, and bit access in the internal RAM.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`include "rcsg_regs.vh"

// Overview of operation
// [RULE_01] Sixteen word general registers live in the internal RAM, not in flops.
// [RULE_02] Every general register address derives from the context base pointer.
// [RULE_03] Any number of banks fits in RAM; banks may overlap each other.
// [RULE_04] Stack up to 1024 bytes in RAM, always addressed via stack top pointer.
// [RULE_05] Each stack access compares pointer against overflow and underflow limits.
// [RULE_06] Exactly 1 KByte of internal RAM holds all on-chip data.
// [RULE_07] Event-transfer unit pointers occupy FCE0h through FCFFh.
// [RULE_08] FD00h through FDFFh supports single-bit reads and writes. A bit read here returns the whole 16-bit word, not the selected bit.
// [RULE_09] A register access finishes within one 40 ns machine cycle at 50 MHz.
// [RULE_10] Word register n sits at context base pointer plus two times n.
// [RULE_11] Distinct overflow and underflow events go to the exception logic.
module rcsg_core (
    // Clock, reset, enable.
    input wire clk,
    input wire srst,
    input wire ce,
    // Register port.
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_q,
    // General register access.
    input wire gpr_rd,
    input wire gpr_wr,
    input wire [3:0] gpr_num,
    input wire [15:0] gpr_wdata,
    output reg [15:0] gpr_rdata_q,
    output reg gpr_rvalid_q,
    // Stack access.
    input wire stk_push,
    input wire stk_pop,
    input wire [15:0] stk_wdata,
    output reg [15:0] stk_rdata_q,
    output reg stk_rvalid_q,
    // Direct memory access, word or single-bit write; a read returns the whole word.
    input wire mem_rd,
    input wire mem_wr,
    input wire mem_bit,
    input wire [15:0] mem_addr,
    input wire [3:0] mem_bitpos,
    input wire [15:0] mem_wdata,
    output reg [15:0] mem_rdata_q,
    output reg mem_rvalid_q,
    output reg mem_err_q,
    output wire ptr_window,
    // Exception events and interrupt.
    output reg stk_ovf_evt_q,
    output reg stk_unf_evt_q,
    output wire irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function in_ram;
        input [15:0] a;
        begin
            in_ram = (a >= `RCSG_RAM_BASE) && (a <= `RCSG_RAM_LAST); // [RULE_06]
        end
    endfunction

    function [8:0] word_idx;
        input [15:0] a;
        reg [15:0] off;
        begin
            off = a - `RCSG_RAM_BASE;
            word_idx = off[9:1];
        end
    endfunction

    function in_bitwin;
        input [15:0] a;
        begin
            in_bitwin = (a >= `RCSG_BIT_LO) && (a <= `RCSG_BIT_HI);
        end
    endfunction

    // A word access must fall in RAM; a single-bit access must also fall in the bit window.
    function mem_ok;
        input [15:0] a;
        input b;
        begin
            mem_ok = in_ram(a) && (!b || in_bitwin(a)); // [RULE_08]
        end
    endfunction

    function sel_wr;
        input wr;
        input [3:0] a;
        input [3:0] ofs;
        begin
            sel_wr = wr && (a == ofs);
        end
    endfunction

    // Pointers and limits are word aligned, so bit 0 is dropped on every write.
    function [15:0] even_ptr;
        input [15:0] d;
        begin
            even_ptr = d & 16'hfffe;
        end
    endfunction

    localparam ST_IDLE = 3'b001;
    localparam ST_READ = 3'b010;
    localparam ST_DONE = 3'b100;

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers.

    reg [15:0] cbp_q;
    reg [15:0] stp_q;
    reg [15:0] ovl_q;
    reg [15:0] unl_q;
    reg [1:0] status_q;
    reg [1:0] mask_q;
    reg ctrl_q;
    reg [2:0] state_q;
    reg [1:0] kind_q;
    reg [15:0] cbp_d;
    reg [15:0] stp_d;

    wire chk_en = ctrl_q;
    wire ovf_hit;
    wire unf_hit;
    wire [15:0] push_addr = stp_q - 16'h0002;
    // A pop yields to a register read or a push in the same cycle and is dropped while a read is in flight.
    wire pop_ok = stk_pop && !gpr_rd && !stk_push && (state_q == ST_IDLE);
    wire pop_go;

    // Pointer limit checks: a push below the overflow limit, a pop at or above the underflow limit.
    assign ovf_hit = chk_en && stk_push && !gpr_wr && (push_addr < ovl_q); // [RULE_05]
    assign unf_hit = chk_en && pop_ok && (stp_q >= unl_q); // [RULE_05]
    assign pop_go = pop_ok && !unf_hit;
    assign irq = |(status_q & mask_q);
    assign ptr_window = (mem_addr >= `RCSG_PTR_LO) && (mem_addr <= `RCSG_PTR_HI); // [RULE_07]

    ////////////////////////////////////////////////////////////////////////////////
    // RAM port selection.

    reg ram_we;
    reg [8:0] ram_waddr;
    reg [15:0] ram_wdata;
    reg [15:0] ram_wmask;
    reg [8:0] ram_raddr;
    wire [15:0] ram_rdata;
    wire [15:0] gpr_addr = cbp_d + {11'h000, gpr_num, 1'b0}; // [RULE_10] [RULE_02] [RULE_03]
    wire [15:0] bit_mask = 16'h0001 << mem_bitpos;

    always @*
    begin
        ram_we = 1'b0;
        ram_waddr = 9'h000;
        ram_wdata = 16'h0000;
        ram_wmask = 16'hffff;
        ram_raddr = 9'h000;
        if (gpr_wr)
        begin
            ram_we = in_ram(gpr_addr);
            ram_waddr = word_idx(gpr_addr); // [RULE_01]
            ram_wdata = gpr_wdata;
        end
        else if (stk_push)
        begin
            ram_we = !ovf_hit && in_ram(push_addr);
            ram_waddr = word_idx(push_addr); // [RULE_04]
            ram_wdata = stk_wdata;
        end
        else if (mem_wr)
        begin
            ram_we = mem_ok(mem_addr, mem_bit);
            ram_waddr = word_idx(mem_addr);
            ram_wdata = mem_bit ? {16{mem_wdata[0]}} : mem_wdata;
            ram_wmask = mem_bit ? bit_mask : 16'hffff; // [RULE_08]
        end
        if (gpr_rd)
        begin
            ram_raddr = word_idx(gpr_addr);
        end
        else if (pop_go)
        begin
            ram_raddr = word_idx(stp_q); // [RULE_04]
        end
        else
        begin
            ram_raddr = word_idx(mem_addr);
        end
    end

    rcsg_ram u_ram (
        .clk(clk),
        .ce(ce),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .wmask(ram_wmask),
        .raddr(ram_raddr),
        .rdata_q(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-value logic for the pointers.

    always @*
    begin
        cbp_d = cbp_q;
        stp_d = stp_q;
        if (sel_wr(reg_wr, reg_addr, `RCSG_OFS_CBP))
        begin
            cbp_d = even_ptr(reg_wdata);
        end
        if (sel_wr(reg_wr, reg_addr, `RCSG_OFS_STP))
        begin
            stp_d = even_ptr(reg_wdata);
        end
        else if (stk_push && !gpr_wr && !ovf_hit)
        begin
            stp_d = push_addr;
        end
        else if (pop_go)
        begin
            stp_d = stp_q + 16'h0002;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequential state.

    always @(posedge clk)
    begin
        if (srst)
        begin
            cbp_q <= `RCSG_CBP_RST;
            stp_q <= `RCSG_STP_RST;
            ovl_q <= `RCSG_OVL_RST;
            unl_q <= `RCSG_UNL_RST;
            status_q <= 2'h0;
            mask_q <= `RCSG_MASK_RST;
            ctrl_q <= `RCSG_CTRL_RST;
            state_q <= ST_IDLE;
            kind_q <= 2'h0;
            reg_rdata_q <= 16'h0000;
            gpr_rdata_q <= 16'h0000;
            gpr_rvalid_q <= 1'b0;
            stk_rdata_q <= 16'h0000;
            stk_rvalid_q <= 1'b0;
            mem_rdata_q <= 16'h0000;
            mem_rvalid_q <= 1'b0;
            mem_err_q <= 1'b0;
            stk_ovf_evt_q <= 1'b0;
            stk_unf_evt_q <= 1'b0;
        end
        else if (ce)
        begin
            cbp_q <= cbp_d;
            stp_q <= stp_d;
            if (sel_wr(reg_wr, reg_addr, `RCSG_OFS_OVL))
            begin
                ovl_q <= even_ptr(reg_wdata);
            end
            if (sel_wr(reg_wr, reg_addr, `RCSG_OFS_UNL))
            begin
                unl_q <= even_ptr(reg_wdata);
            end
            if (sel_wr(reg_wr, reg_addr, `RCSG_OFS_MASK))
            begin
                mask_q <= reg_wdata[1:0];
            end
            if (sel_wr(reg_wr, reg_addr, `RCSG_OFS_CTRL))
            begin
                ctrl_q <= reg_wdata[`RCSG_CTRL_CHK_EN];
            end
            // Set wins over a write-one clear in the same cycle.
            status_q[`RCSG_ST_OVF] <= ovf_hit ||
                (status_q[`RCSG_ST_OVF] && !(sel_wr(reg_wr, reg_addr, `RCSG_OFS_STATUS) && reg_wdata[`RCSG_ST_OVF]));
            status_q[`RCSG_ST_UNF] <= unf_hit ||
                (status_q[`RCSG_ST_UNF] && !(sel_wr(reg_wr, reg_addr, `RCSG_OFS_STATUS) && reg_wdata[`RCSG_ST_UNF]));
            stk_ovf_evt_q <= ovf_hit; // [RULE_11]
            stk_unf_evt_q <= unf_hit; // [RULE_11]
            reg_rdata_q <= 16'h0000;
            if (reg_rd)
            begin
                case (reg_addr)
                    `RCSG_OFS_CBP: reg_rdata_q <= cbp_q;
                    `RCSG_OFS_STP: reg_rdata_q <= stp_q;
                    `RCSG_OFS_OVL: reg_rdata_q <= ovl_q;
                    `RCSG_OFS_UNL: reg_rdata_q <= unl_q;
                    `RCSG_OFS_STATUS: reg_rdata_q <= {14'h0000, status_q};
                    `RCSG_OFS_MASK: reg_rdata_q <= {14'h0000, mask_q};
                    `RCSG_OFS_CTRL: reg_rdata_q <= {15'h0000, ctrl_q};
                    default: reg_rdata_q <= 16'h0000;
                endcase
            end
            // The RAM answers one clock after the request, so a read ends within one machine cycle.
            gpr_rvalid_q <= 1'b0;
            stk_rvalid_q <= 1'b0;
            mem_rvalid_q <= 1'b0;
            mem_err_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (gpr_rd || pop_go || mem_rd)
                    begin
                        state_q <= ST_READ; // [RULE_09]
                        kind_q <= gpr_rd ? 2'h0 : (pop_go ? 2'h1 : 2'h2);
                        if (!gpr_rd && !pop_go && mem_rd)
                        begin
                            kind_q <= mem_ok(mem_addr, mem_bit) ? 2'h2 : 2'h3;
                        end
                    end
                end
                ST_READ:
                begin
                    state_q <= ST_IDLE;
                    case (kind_q)
                        2'h0:
                        begin
                            gpr_rdata_q <= ram_rdata;
                            gpr_rvalid_q <= 1'b1;
                        end
                        2'h1:
                        begin
                            stk_rdata_q <= ram_rdata;
                            stk_rvalid_q <= 1'b1;
                        end
                        2'h2:
                        begin
                            mem_rdata_q <= ram_rdata;
                            mem_rvalid_q <= 1'b1;
                        end
                        default:
                        begin
                            mem_rdata_q <= 16'h0000;
                            mem_rvalid_q <= 1'b1;
                            mem_err_q <= 1'b1;
                        end
                    endcase
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // rcsg_core

/* File: testbench/rcsg_core_assertions.sv */
// Concurrent checks on the ports of the context and stack guard core.
module rcsg_core_assertions (
    // Clock and reset.
    input logic clk,
    input logic srst,
    input logic ce,
    // Requests, and the register read data.
    input logic reg_rd,
    input logic [15:0] reg_rdata_q,
    input logic gpr_rd,
    input logic stk_push,
    input logic stk_pop,
    input logic mem_rd,
    input logic mem_bit,
    input logic [15:0] mem_addr,
    // Answers and events.
    input logic gpr_rvalid_q,
    input logic stk_rvalid_q,
    input logic mem_rvalid_q,
    input logic ptr_window,
    input logic stk_ovf_evt_q,
    input logic stk_unf_evt_q,
    input logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    a_gpr_rd_lat: assert property (ce && gpr_rd && !$past(gpr_rd || stk_pop || mem_rd) |-> ##2 gpr_rvalid_q)
        else $error("register read not answered in two cycles");
    a_gpr_valid_cause: assert property (gpr_rvalid_q |-> $past(gpr_rd, 2))
        else $error("register read answer without request");
    a_stk_valid_cause: assert property (stk_rvalid_q |-> $past(stk_pop, 2) && !$past(stk_unf_evt_q))
        else $error("stack answer without legal pop");
    a_ovf_cause: assert property (stk_ovf_evt_q |-> $past(stk_push) && !stk_unf_evt_q)
        else $error("overflow event without push");
    a_unf_cause: assert property (stk_unf_evt_q |-> $past(stk_pop))
        else $error("underflow event without pop");
    a_ptr_window: assert property (ptr_window == (mem_addr >= 16'hfce0 && mem_addr <= 16'hfcff))
        else $error("pointer window flag wrong");
    a_mem_rd_lat: assert property (ce && mem_rd && !mem_bit && !gpr_rd && !stk_pop && !stk_push
        && mem_addr >= 16'hfa00 && mem_addr <= 16'hfdff && !$past(gpr_rd || stk_pop || mem_rd) |-> ##2 mem_rvalid_q)
        else $error("memory read not answered in two cycles");
    a_reg_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0)
        else $error("register read data outside its cycle");
    a_irq_after_rst: assert property ($fell(srst) |-> !irq && !stk_ovf_evt_q && !stk_unf_evt_q)
        else $error("event or interrupt active after reset");
endmodule // rcsg_core_assertions

/* File: testbench/rcsg_cpu_model.sv */
// Behavioural CPU-side requester driving one strobe at a time with shared address and data.
module rcsg_cpu_model (
    // Clock.
    input logic clk,
    // Strobes: 0 reg_wr, 1 reg_rd, 2 gpr_wr, 3 gpr_rd, 4 push, 5 pop, 6 mem_wr, 7 mem_rd.
    output logic [7:0] stb,
    output logic [15:0] adr,
    output logic [15:0] dat,
    output logic bitm
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        stb = 8'h0;
        adr = 16'h0;
        dat = 16'h0;
        bitm = 1'b0;
    end
    // Released qualifiers flip so the core cannot lean on stale values.
    task automatic go(input int k, input logic [15:0] a, input logic [15:0] d, input logic b);
        stb[k] <= 1'b1;
        adr <= a;
        dat <= d;
        bitm <= b;
        @(posedge clk);
        stb <= 8'h0;
        adr <= ~a;
        dat <= ~d;
        bitm <= ~b;
        repeat (3) @(posedge clk);
    endtask
endmodule // rcsg_cpu_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the context and stack guard core.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic [15:0] v;} rcsg_note_t;
    logic clk, srst, ce, rrd_q, bitm, mem_err_q, ptr_window, ovf, unf, irq, gv, sv, mv;
    logic [7:0] stb;
    logic [15:0] adr, dat, rd_r, rd_g, rd_s, rd_m;
    logic [15:0] v[16];
    logic [15:0] rst_v[8] = '{16'hfc00, 16'hfc00, 16'hfa00, 16'hfc00, 16'h0, 16'h0, 16'h1, 16'h0};
    rcsg_note_t q[$];
    int fails = 0, n_checks = 0, seed = 25280, i;
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    rcsg_core i_dut (.clk(clk), .srst(srst), .ce(ce), .reg_addr(adr[3:0]), .reg_wdata(dat), .reg_wr(stb[0]),
        .reg_rd(stb[1]), .reg_rdata_q(rd_r), .gpr_rd(stb[3]), .gpr_wr(stb[2]), .gpr_num(adr[3:0]), .gpr_wdata(dat),
        .gpr_rdata_q(rd_g), .gpr_rvalid_q(gv), .stk_push(stb[4]), .stk_pop(stb[5]), .stk_wdata(dat),
        .stk_rdata_q(rd_s), .stk_rvalid_q(sv), .mem_rd(stb[7]), .mem_wr(stb[6]), .mem_bit(bitm), .mem_addr(adr),
        .mem_bitpos(dat[11:8]), .mem_wdata(dat), .mem_rdata_q(rd_m), .mem_rvalid_q(mv), .mem_err_q(mem_err_q),
        .ptr_window(ptr_window), .stk_ovf_evt_q(ovf), .stk_unf_evt_q(unf), .irq(irq));
    rcsg_cpu_model i_cpu (.clk(clk), .stb(stb), .adr(adr), .dat(dat), .bitm(bitm));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic exp(input string nm, input logic [15:0] e);
        q.push_back('{nm, e});
    endtask
    task automatic take(input logic [15:0] s);
        rcsg_note_t n;
        n.nm = "extra";
        n.v = 16'hxxxx;
        if (q.size() != 0)
            n = q.pop_front();
        check(n.nm, s, n.v);
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Each answer takes the oldest note; events are noted as {error, underflow, overflow}.
    always @(posedge clk)
    begin
        rrd_q <= stb[1];
        if (rrd_q) take(rd_r);
        if (gv) take(rd_g);
        if (sv) take(rd_s);
        if (mv) take(rd_m);
        if (ovf || unf || mem_err_q) take({13'h0, mem_err_q, unf, ovf});
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        rrd_q = 1'b0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        i_cpu.go(0, 16'h7, 16'hffff, 1'b0);
        for (i = 0; i < 8; i++)
        begin
            exp("reg", rst_v[i]);
            i_cpu.go(1, i[15:0], 16'h0, 1'b0);
        end
        for (i = 0; i < 16; i++)
        begin
            v[i] = 16'($random(seed));
            i_cpu.go(2, i[15:0], v[i], 1'b0);
        end
        for (i = 0; i < 16; i++)
        begin
            exp("gpr", v[i]);
            i_cpu.go(3, i[15:0], 16'h0, 1'b0);
        end
        exp("gprmem", v[3]);
        i_cpu.go(7, 16'hfc06, 16'h0, 1'b0);
        i_cpu.go(0, 16'h0, 16'hfc08, 1'b0);
        exp("overlap", v[4]);
        i_cpu.go(3, 16'h0, 16'h0, 1'b0);
        ce <= 1'b0;
        i_cpu.go(0, 16'h0, 16'h1234, 1'b0);
        ce <= 1'b1;
        exp("frozen", 16'hfc08);
        i_cpu.go(1, 16'h0, 16'h0, 1'b0);
        exp("unf", 16'h2);
        i_cpu.go(5, 16'h0, 16'h0, 1'b0);
        for (i = 0; i < 3; i++) i_cpu.go(4, 16'h0, v[i], 1'b0);
        for (i = 2; i >= 0; i--)
        begin
            exp("pop", v[i]);
            i_cpu.go(5, 16'h0, 16'h0, 1'b0);
        end
        i_cpu.go(0, 16'h2, 16'hfbfe, 1'b0);
        i_cpu.go(4, 16'h0, v[5], 1'b0);
        exp("ovf", 16'h1);
        i_cpu.go(4, 16'h0, v[6], 1'b0);
        exp("stkmem", v[5]);
        i_cpu.go(7, 16'hfbfe, 16'h0, 1'b0);
        exp("status", 16'h3);
        i_cpu.go(1, 16'h4, 16'h0, 1'b0);
        check("irq", {15'h0, irq}, 16'h0);
        i_cpu.go(0, 16'h5, 16'h3, 1'b0);
        check("irq", {15'h0, irq}, 16'h1);
        i_cpu.go(0, 16'h4, 16'h1, 1'b0);
        check("irq", {15'h0, irq}, 16'h1);
        i_cpu.go(0, 16'h4, 16'h2, 1'b0);
        check("irq", {15'h0, irq}, 16'h0);
        i_cpu.go(0, 16'h6, 16'h0, 1'b0);
        i_cpu.go(4, 16'h0, v[9], 1'b0);
        exp("unchk", v[9]);
        i_cpu.go(7, 16'hfbfc, 16'h0, 1'b0);
        exp("unchkstp", 16'hfbfc);
        i_cpu.go(1, 16'h1, 16'h0, 1'b0);
        i_cpu.go(0, 16'h6, 16'h1, 1'b0);
        i_cpu.go(6, 16'hfd02, 16'h0, 1'b0);
        i_cpu.go(6, 16'hfd02, 16'h0501, 1'b1);
        exp("bit", 16'h0020);
        i_cpu.go(7, 16'hfd02, 16'h0, 1'b0);
        i_cpu.go(6, 16'hfc02, 16'h0501, 1'b1);
        exp("nobit", v[1]);
        i_cpu.go(7, 16'hfc02, 16'h0, 1'b0);
        i_cpu.go(6, 16'hfa00, v[7], 1'b0);
        i_cpu.go(6, 16'hfce0, v[8], 1'b0);
        exp("ramerr", 16'h0);
        exp("err", 16'h4);
        i_cpu.go(7, 16'hf9fe, 16'h0, 1'b0);
        exp("ramlo", v[7]);
        i_cpu.go(7, 16'hfa00, 16'h0, 1'b0);
        exp("ptr", v[8]);
        i_cpu.go(7, 16'hfce0, 16'h0, 1'b0);
        repeat (4) @(posedge clk);
        check("left", 16'(q.size()), 16'h0);
        stop_test();
    end
endmodule // tb_top
bind rcsg_core rcsg_core_assertions i_chk (.clk(clk), .srst(srst), .ce(ce), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .gpr_rd(gpr_rd), .stk_push(stk_push), .stk_pop(stk_pop), .mem_rd(mem_rd),
    .mem_bit(mem_bit), .mem_addr(mem_addr), .gpr_rvalid_q(gpr_rvalid_q), .stk_rvalid_q(stk_rvalid_q),
    .mem_rvalid_q(mem_rvalid_q), .ptr_window(ptr_window), .stk_ovf_evt_q(stk_ovf_evt_q),
    .stk_unf_evt_q(stk_unf_evt_q), .irq(irq));
